// File: core/eer_pkg.sv
// constants shared by the error status readout block
package eer_pkg;
   // ************************************************************
   // word address and group layout
   // ************************************************************
   localparam int          ADDR_W      = 15;      // byte word address width
   localparam int          GROUP_W     = 13;      // four-byte group index width
   localparam int          DATA_W      = 32;      // data bits of one group
   localparam int          CW_W        = 38;      // stored codeword width
   localparam int          SYN_W       = 6;       // syndrome width
   localparam int          SEL_HI      = 10;      // upper bit of area select field
   localparam int          SEL_LO      = 9;       // lower bit of area select field
   localparam logic [1:0]  SEL_ESR     = 2'h3;    // area code of the error flag
   localparam logic [7:0]  ESR_ERR     = 8'hff;   // byte sent when flag is set
   localparam logic [7:0]  ESR_OK      = 8'h00;   // byte sent when flag is clear
   localparam logic        FLAG_RESET  = 1'b0;    // flag value after reset
   localparam logic [3:0]  BITS_BYTE   = 4'h8;    // bits in one byte
   localparam logic [1:0]  WB_LO       = 2'h1;    // index of low word address byte
   localparam logic [1:0]  WB_DATA     = 2'h2;    // index of first data byte
   // ************************************************************
   // serial engine states
   // ************************************************************
   typedef enum logic [5:0] {
      EER_IDLE   = 6'h01,
      EER_DEVA   = 6'h02,
      EER_ACKTX  = 6'h04,
      EER_WADDR  = 6'h08,
      EER_RDATA  = 6'h10,
      EER_ACKRX  = 6'h20
   } eer_state_t;
endpackage

// File: core/eer_ecc_dec.sv
// single error correcting decoder for one stored four-byte group
`timescale 1ns/10ps
module eer_ecc_dec
(
   input  wire logic                         clk_i,     // system clock
   input  wire logic                         rst_n_i,   // sync reset, low
   input  wire logic                         vld_i,     // codeword valid
   input  wire logic [eer_pkg::CW_W-1:0]     cw_i,      // stored codeword
   output logic      [eer_pkg::DATA_W-1:0]   data_o,    // corrected data
   output logic                              corr_o     // a bit was corrected
);

   logic [eer_pkg::SYN_W-1:0]  syn;
   logic [eer_pkg::CW_W-1:0]   fixed;
   logic [eer_pkg::DATA_W-1:0] dat;

   // syndrome, single bit repair and data extraction
   always_comb
   begin
      int k;
      k     = 0;
      syn   = '0;
      fixed = cw_i;
      dat   = '0;
      for (int p = 0; p < eer_pkg::SYN_W; p++)
      begin
         for (int i = 0; i < eer_pkg::CW_W; i++)
         begin
            if ((((i + 1) >> p) & 1) == 1)
            begin
               syn[p] = syn[p] ^ cw_i[i];
            end
         end
      end
      for (int i = 0; i < eer_pkg::CW_W; i++)
      begin
         if (32'(syn) == i + 1)
         begin
            fixed[i] = ~cw_i[i];
         end
      end
      for (int i = 0; i < eer_pkg::CW_W; i++)
      begin
         if (((i + 1) & i) != 0)
         begin
            dat[k] = fixed[i];
            k      = k + 1;
         end
      end
   end

   // registered result
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         data_o <= '0;
         corr_o <= 1'b0;
      end
      else if (vld_i)
      begin
         data_o <= dat;
         corr_o <= (syn != '0);
      end
   end
endmodule

// File: core/eer_status_top.sv
// two-wire serial memory read path with error status flag readout
// ************************************************************
// ************************************************************
`timescale 1ns/10ps
module eer_status_top
#(
   parameter logic [6:0] MEM_DEV = 7'h50,   // array device address, arbitrary
   parameter logic [6:0] SEC_DEV = 7'h58    // special area device address, arbitrary
)
(
   input  wire logic                          clk_i,          // 25 MHz clock
   input  wire logic                          rst_n_i,        // sync reset, low
   input  wire logic                          scl_i,          // serial clock pin
   input  wire logic                          sda_i,          // serial data pin in
   output logic                               sda_o,          // serial data out, always 0
   output logic                               sda_oe_o,       // pull data line low
   output logic                               mem_rd_o,       // group fetch strobe
   output logic      [eer_pkg::GROUP_W-1:0]   mem_addr_o,     // group index
   input  wire logic [eer_pkg::CW_W-1:0]      mem_rdata_i,    // codeword, cycle after strobe
   output logic                               ecc_error_flag_o // flag state
);

   // ************************************************************
   // pin synchronisers and bus events
   // ************************************************************
   logic        scl_m, scl_s, scl_d;
   logic        sda_m, sda_s, sda_d;
   logic        scl_rise, scl_fall, bus_start, bus_stop;

   // two flops per pin, then one history flop
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
      end
      else
      begin
         scl_m <= scl_i;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_i;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   // edge and condition detection
   assign scl_rise  = scl_s & ~scl_d;
   assign scl_fall  = ~scl_s & scl_d;
   assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
   assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

   // ************************************************************
   // serial engine
   // ************************************************************
   eer_pkg::eer_state_t              state;
   logic [3:0]                       bitcnt;
   logic [7:0]                       rx_sh;
   logic [7:0]                       tx_sh;
   logic [1:0]                       wbyte;
   logic [6:0]                       addr_hi;
   logic [eer_pkg::ADDR_W-1:0]       waddr;
   logic                             rw;
   logic                             sec_sel;
   logic                             acked;
   logic                             esr_busy;
   logic                             fetch;
   logic                             load;
   logic                             rd_q;
   logic                             esr_mode;
   logic [7:0]                       next_byte;
   logic [eer_pkg::DATA_W-1:0]       grp_data;
   logic                             grp_corr;
   logic                             dev_hit;

   // flag read when special device address and area code 11
   assign esr_mode = sec_sel & (waddr[eer_pkg::SEL_HI:eer_pkg::SEL_LO] == eer_pkg::SEL_ESR);
   assign dev_hit  = (rx_sh[7:1] == MEM_DEV) | (rx_sh[7:1] == SEC_DEV);
   assign fetch    = scl_rise & (((state == eer_pkg::EER_ACKTX) & rw) |
                                 ((state == eer_pkg::EER_ACKRX) & ~sda_s));
   assign load     = scl_fall & (((state == eer_pkg::EER_ACKTX) & rw) |
                                 ((state == eer_pkg::EER_ACKRX) & acked));

   // byte chosen for transmission: flag byte or corrected array byte
   assign next_byte = esr_mode ? (ecc_error_flag_o ? eer_pkg::ESR_ERR : eer_pkg::ESR_OK)
                               : grp_data[8*waddr[1:0] +: 8];

   // state and bit sequencing
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state    <= eer_pkg::EER_IDLE;
         bitcnt   <= '0;
         rx_sh    <= '0;
         tx_sh    <= '0;
         wbyte    <= '0;
         rw       <= 1'b0;
         sec_sel  <= 1'b0;
         acked    <= 1'b0;
         sda_oe_o <= 1'b0;
      end
      else if (bus_start)
      begin
         state    <= eer_pkg::EER_DEVA;
         bitcnt   <= '0;
         sda_oe_o <= 1'b0;
      end
      else if (bus_stop)
      begin
         state    <= eer_pkg::EER_IDLE;
         sda_oe_o <= 1'b0;
      end
      else
      begin
         case (state)
            eer_pkg::EER_DEVA, eer_pkg::EER_WADDR:
            begin
               if (scl_rise)
               begin
                  rx_sh  <= {rx_sh[6:0], sda_s};
                  bitcnt <= bitcnt + 4'h1;
               end
               else if (scl_fall && bitcnt == eer_pkg::BITS_BYTE)
               begin
                  bitcnt <= '0;
                  if (state == eer_pkg::EER_DEVA)
                  begin
                     if (dev_hit)
                     begin
                        sec_sel  <= (rx_sh[7:1] == SEC_DEV);
                        rw       <= rx_sh[0];
                        wbyte    <= '0;
                        sda_oe_o <= 1'b1;
                        state    <= eer_pkg::EER_ACKTX;
                     end
                     else
                     begin
                        state <= eer_pkg::EER_IDLE;
                     end
                  end
                  else
                  begin
                     if (wbyte != eer_pkg::WB_DATA)
                        wbyte <= wbyte + 2'h1;
                     sda_oe_o <= 1'b1;
                     state    <= eer_pkg::EER_ACKTX;
                  end
               end
            end
            eer_pkg::EER_ACKTX:
            begin
               if (load)
               begin
                  tx_sh    <= next_byte;
                  sda_oe_o <= ~next_byte[7];
                  bitcnt   <= 4'h1;
                  state    <= eer_pkg::EER_RDATA;
               end
               else if (scl_fall)
               begin
                  sda_oe_o <= 1'b0;
                  state    <= eer_pkg::EER_WADDR;
               end
            end
            eer_pkg::EER_RDATA:
            begin
               if (scl_fall)
               begin
                  if (bitcnt == eer_pkg::BITS_BYTE)
                  begin
                     sda_oe_o <= 1'b0;
                     state    <= eer_pkg::EER_ACKRX;
                  end
                  else
                  begin
                     sda_oe_o <= ~tx_sh[6];
                     tx_sh    <= {tx_sh[6:0], 1'b0};
                     bitcnt   <= bitcnt + 4'h1;
                  end
               end
            end
            eer_pkg::EER_ACKRX:
            begin
               if (scl_rise)
               begin
                  acked <= ~sda_s;
               end
               else if (load)
               begin
                  tx_sh    <= next_byte;
                  sda_oe_o <= ~next_byte[7];
                  bitcnt   <= 4'h1;
                  state    <= eer_pkg::EER_RDATA;
               end
               else if (scl_fall)
               begin
                  state <= eer_pkg::EER_IDLE;                        // nack, wait for stop
               end
            end
            default:
            begin
               state    <= eer_pkg::EER_IDLE;
               sda_oe_o <= 1'b0;
            end
         endcase
      end
   end

   // word address load and read increment
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         addr_hi <= '0;
         waddr   <= '0;
      end
      else if (state == eer_pkg::EER_WADDR && scl_fall && bitcnt == eer_pkg::BITS_BYTE)
      begin
         if (wbyte == '0)
            addr_hi <= rx_sh[6:0];
         else if (wbyte == eer_pkg::WB_LO)
            waddr <= {addr_hi, rx_sh};
      end
      else if (load && !esr_mode)
         waddr <= waddr + 15'h0001;
   end

   // ************************************************************
   // group fetch and correction
   // ************************************************************
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         mem_rd_o   <= 1'b0;
         mem_addr_o <= '0;
         rd_q       <= 1'b0;
         sda_o      <= 1'b0;
      end
      else
      begin
         mem_rd_o   <= fetch;
         mem_addr_o <= waddr[eer_pkg::ADDR_W-1:2];
         rd_q       <= mem_rd_o;
         sda_o      <= 1'b0;
      end
   end

   eer_ecc_dec u_dec
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .vld_i   (rd_q),
      .cw_i    (mem_rdata_i),
      .data_o  (grp_data),
      .corr_o  (grp_corr)
   );

   // ************************************************************
   // error status flag
   // ************************************************************
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         ecc_error_flag_o <= eer_pkg::FLAG_RESET;
         esr_busy         <= 1'b0;
      end
      else if (load && !esr_mode && grp_corr)
      begin
         ecc_error_flag_o <= 1'b1;
      end
      else if (esr_busy && (bus_stop || bus_start))
      begin
         ecc_error_flag_o <= 1'b0;
         esr_busy         <= 1'b0;
      end
      else if (load && esr_mode)
         esr_busy <= 1'b1;
   end
endmodule

// File: testbench/eer_status_chk.sv
// port assertions for the error status readout block
`timescale 1ns/10ps
module eer_status_chk
(
   input  wire logic                         clk_i,           // system clock
   input  wire logic                         rst_n_i,         // sync reset, low
   input  wire logic                         scl_i,           // serial clock pin
   input  wire logic                         sda_i,           // serial data pin
   input  wire logic                         sda_o,           // data drive value
   input  wire logic                         sda_oe_o,        // data pull enable
   input  wire logic                         mem_rd_o,        // group fetch strobe
   input  wire logic [eer_pkg::GROUP_W-1:0]  mem_addr_o,      // group index
   input  wire logic [eer_pkg::CW_W-1:0]     mem_rdata_i,     // codeword
   input  wire logic                         ecc_error_flag_o // flag state
);
   logic [7:0] since_rd;   // cycles since last fetch
   // ********************
   // helper counter
   // ********************
   // counts up from each fetch strobe, saturating
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || mem_rd_o)
         since_rd <= 8'h00;
      else if (since_rd != 8'hff)
         since_rd <= since_rd + 8'h01;
   end
   // ********************
   // assertions
   // ********************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence scl_held;
      scl_i [*3];
   endsequence
   sequence fetch_quiet;
      !mem_rd_o [*8];
   endsequence
   chk_reset_idle: assert property ($rose(rst_n_i) |-> !ecc_error_flag_o && !sda_oe_o && !mem_rd_o)
      else $error("outputs not idle after reset");
   chk_fetch_spacing: assert property (mem_rd_o |=> fetch_quiet)
      else $error("fetch strobe repeated too soon");
   chk_set_after_fetch: assert property ($rose(ecc_error_flag_o) |-> since_rd < 8'h10)
      else $error("flag set without a recent fetch");
   chk_set_scl_low: assert property ($rose(ecc_error_flag_o) |-> !scl_i)
      else $error("flag set outside the clock low phase");
   chk_clear_at_stop: assert property ($fell(ecc_error_flag_o) |-> scl_i && sda_i)
      else $error("flag cleared outside a stop");
   chk_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data drive changed while clock high");
   chk_oe_hold_high: assert property (scl_held |-> $stable(sda_oe_o))
      else $error("data drive unstable in high phase");
   chk_drive_low_only: assert property (sda_o == 1'b0)
      else $error("data line driven high");
endmodule
bind eer_status_top eer_status_chk i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
   .mem_rdata_i(mem_rdata_i), .ecc_error_flag_o(ecc_error_flag_o));

// File: testbench/eer_i2c_master.sv
// two-wire bus master model driving the block's serial pins
`timescale 1ns/10ps
module eer_i2c_master
(
   input  wire logic  sda_i,    // resolved data line
   output logic       scl_o,    // serial clock, idle high
   output logic       sda_oe_o  // pull data line low
);
   logic [7:0] q [0:7];   // bytes of the last read
   int         miss;      // missing device acks
   // idle bus: clock stands high, data released
   initial
   begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
      miss = 0;
   end
   // one bit: drive in low phase, sample in high phase
   task automatic bit_x(input logic b, output logic r);
      sda_oe_o = !b;
      #80 scl_o = 1'b1;
      #80 r = sda_i;
      #80 scl_o = 1'b0;
      #80;
   endtask
   // start when st is high, stop otherwise
   task automatic cond(input logic st);
      sda_oe_o = !st;
      #80 scl_o = 1'b1;
      #80 sda_oe_o = st;
      #80 scl_o = !st;
      #80;
   endtask
   // send a byte, count a missing ack
   task automatic put(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(b[i], r);
      bit_x(1'b1, r);
      if (r)
         miss++;
   endtask
   // receive byte k, ack unless last
   task automatic get(input int k, input logic last);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(1'b1, r);
         q[k][i] = r;
      end
      bit_x(last, r);
   endtask
   // random read of n bytes from word address a
   task automatic xfer(input logic [6:0] dev, input logic [14:0] a, input int n);
      cond(1'b1);
      put({dev, 1'b0});
      put({1'b0, a[14:8]});
      put(a[7:0]);
      cond(1'b1);
      put({dev, 1'b1});
      for (int k = 0; k < n; k++)
         get(k, k == n - 1);
      cond(1'b0);
   endtask
endmodule

// File: testbench/test_ecc_error_status_readout.sv
// self-checking bench for the error status readout block
`timescale 1ns/10ps
module test_ecc_error_status_readout;
   localparam logic [6:0] MEM_DEV = 7'h50;   // array address, arbitrary
   localparam logic [6:0] SEC_DEV = 7'h58;   // special area address, arbitrary
   logic        clk       = 1'b0;   // system clock
   logic        rst_n     = 1'b0;   // sync reset, low
   logic        scl;                // serial clock
   logic        dev_oe;             // device pulls data low
   logic        mst_oe;             // master pulls data low
   wire         sda;                // pulled-up data line
   logic        mem_rd;             // fetch strobe
   logic [12:0] mem_addr;           // group index
   logic [37:0] mem_rdata = 38'h0;  // stored codeword
   logic        flag;               // flag state
   int          bad_count = 0;      // mismatches
   int          n_compared = 0;     // comparisons
   assign sda = !(dev_oe || mst_oe);
   // clock
   initial
      forever #20 clk = !clk;
   // byte pattern of each array address
   function automatic logic [7:0] byt(input logic [14:0] a);
      return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5a;
   endfunction
   // hamming codeword, parity at power-of-two positions
   function automatic logic [37:0] enc(input logic [31:0] d);
      logic [37:0] c;
      int          k;
      c = 38'h0;
      k = 0;
      for (int p = 1; p <= 38; p++)
         if ((p & (p - 1)) != 0)
         begin
            c[p-1] = d[k];
            k++;
         end
      for (int j = 0; j < 6; j++)
         for (int p = 1; p <= 38; p++)
            if (p[j] && p != (1 << j))
               c[(1<<j)-1] ^= c[p-1];
      return c;
   endfunction
   // array model: group 3 has a data bit flipped, group 5 a check bit
   always @(negedge clk)
      mem_rdata <= enc({byt({mem_addr, 2'h3}), byt({mem_addr, 2'h2}), byt({mem_addr, 2'h1}),
         byt({mem_addr, 2'h0})}) ^ (mem_addr == 13'h3 ? 38'h4 : mem_addr == 13'h5 ? 38'h8 : 38'h0);
   eer_status_top #(.MEM_DEV(MEM_DEV), .SEC_DEV(SEC_DEV)) i_dut
   (
      .clk_i            (clk),
      .rst_n_i          (rst_n),
      .scl_i            (scl),
      .sda_i            (sda),
      .sda_o            (),
      .sda_oe_o         (dev_oe),
      .mem_rd_o         (mem_rd),
      .mem_addr_o       (mem_addr),
      .mem_rdata_i      (mem_rdata),
      .ecc_error_flag_o (flag)
   );
   eer_i2c_master i_mst
   (
      .sda_i    (sda),
      .scl_o    (scl),
      .sda_oe_o (mst_oe)
   );
   // ********************
   // check tasks
   // ********************
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("BAD %s exp %h got %h", nm, e, g);
         bad_count++;
      end
   endtask
   // read a whole group and compare each byte
   task automatic rd_group(input logic [12:0] g);
      i_mst.xfer(MEM_DEV, {g, 2'h0}, 4);
      for (int b = 0; b < 4; b++)
         chk("array byte", byt({g, b[1:0]}), i_mst.q[b]);
   endtask
   // read the flag twice over and see it cleared after
   task automatic rd_flag(input logic [14:0] a, input logic [7:0] e);
      i_mst.xfer(SEC_DEV, a, 2);
      chk("flag byte", e, i_mst.q[0]);
      chk("flag repeat", e, i_mst.q[1]);
      chk("flag after read", 8'h00, {7'h0, flag});
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ********************
   // tests
   // ********************
   initial
   begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("flag at reset", 8'h00, {7'h0, flag});
      rd_flag(15'h7e5a, 8'h00);
      rd_group(13'h2);
      chk("flag clean", 8'h00, {7'h0, flag});
      rd_group(13'h3);
      chk("flag raised", 8'h01, {7'h0, flag});
      rd_flag(15'h0600, 8'hff);
      rd_flag(15'h0600, 8'h00);
      for (int g = 4; g < 6; g++)
      begin
         rd_group(g[12:0]);
         rd_flag(15'h0600, g == 5 ? 8'hff : 8'h00);
      end
      i_mst.xfer(SEC_DEV, 15'h0208, 1);
      chk("other area", byt(15'h0208), i_mst.q[0]);
      chk("missed acks", 8'h00, i_mst.miss[7:0]);
      i_mst.xfer(7'h22, 15'h0000, 1);
      chk("foreign byte", 8'hff, i_mst.q[0]);
      chk("foreign acks", 8'h04, i_mst.miss[7:0]);
      report_and_stop();
   end
   // watchdog
   initial
   begin
      #2000000;
      bad_count++;
      $display("BAD watchdog exp done got hang");
      report_and_stop();
   end
endmodule
